// ===== include/usb_ctl_pkg.sv
// constants for the usb control and address register block
// assumes a 32-bit apb slave at a 20 MHz pclk
package usb_ctl_pkg;
  localparam logic [11:0] off_usb_control        = 12'h000;
  localparam logic [11:0] off_usb_device_address = 12'h004;
  localparam logic [11:0] off_token_command      = 12'h008;
  localparam logic [11:0] off_core_state         = 12'h00C;

  // control register field positions
  localparam int bit_live_idle_line    = 7;
  localparam int bit_live_se0          = 6;
  localparam int bit_packet_disable    = 5;
  localparam int bit_bus_reset_drive   = 4;
  localparam int bit_host_enable       = 3;
  localparam int bit_resume            = 2;
  localparam int bit_pingpong_reset    = 1;
  localparam int bit_module_enable     = 0;
  // address register field positions
  localparam int bit_low_speed_select  = 7;
  localparam int addr_field_width      = 7;

  localparam logic [7:0] control_reset_value = 8'h00;
  localparam logic [7:0] address_reset_value = 8'h00;
  localparam logic [7:0] token_reset_value   = 8'h00;

  localparam logic [3:0] pid_setup = 4'hD;
  localparam logic [3:0] pid_in    = 4'h9;
  localparam logic [3:0] pid_out   = 4'h1;

  // timing
  localparam int clk_hz           = 20000000;
  localparam int sof_period_us    = 1000;
  localparam int sof_period_cycles = clk_hz / 1000000 * sof_period_us;
  localparam int ls_eop_ns        = 1330;
  localparam int ls_eop_cycles    = (ls_eop_ns * 20 + 999) / 1000;
  localparam int token_busy_cycles = 64;
endpackage : usb_ctl_pkg

// ===== rtl/usb_control_and_address_regs.sv
// usb control and device address registers behind an apb slave
// assumes synchronous line-state inputs and a token engine outside
// that reports completion with token_done
//
// Overview of operation
// R01: control bit 7 reads live j line state.
// R02: control bit 6 reads live single-ended zero.
// R03: device mode: setup token sets packet disable; processing halts.
// R04: host mode: bit 5 reads token busy while token executes.
// R05: host software checks token busy before writing another token.
// R06: host mode: bus reset bit drives usb reset signalling.
// R07: host enable bit turns host capability on or off.
// R08: any host enable change resets all host control logic.
// R09: resume bit drives resume signalling while set.
// R10: software holds resume 10 ms function or 25 ms host.
// R11: host mode: clearing resume appends a low-speed eop.
// R12: ping-pong reset forces all pointers to the even bank.
// R13: device mode: bit 0 enables module and circuitry.
// R14: host mode: bit 0 enables sof every 1 ms.
// R15: low-speed select makes next token run at low speed.
// R16: address register holds 7-bit address, reset zero.
// R17: bits 31-8 of both registers ignore writes, read zero.
// R18: token codes: setup 1101, in 1001, out 0001.
// R19: device software clears packet disable after setup handling.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module usb_control_and_address_regs #(
  parameter int sof_cycles = usb_ctl_pkg::sof_period_cycles
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        line_j_state,
  input  wire logic        line_se0,
  input  wire logic        setup_token_seen,
  input  wire logic        token_done,
  output logic             processing_enabled,
  output logic             bus_reset_out,
  output logic             resume_out,
  output logic             ls_eop_out,
  output logic             host_mode,
  output logic             host_logic_reset,
  output logic             pingpong_even,
  output logic             module_enabled,
  output logic             sof_pulse,
  output logic             token_start,
  output logic [3:0]       token_pid,
  output logic [3:0]       token_ep,
  output logic             token_low_speed,
  output logic [6:0]       device_address
);
  import usb_ctl_pkg::*;

  typedef enum {tok_idle, tok_busy} tok_state_t;

  logic [7:0]  ctrl_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  tok_reg;
  logic        j_reg;
  logic        se0_reg;
  logic        pkt_dis_reg;
  tok_state_t  tok_state_reg;
  logic [15:0] sof_cnt_reg;
  logic [7:0]  eop_cnt_reg;
  logic [7:0]  ctrl_next;

  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_addr;
  logic hit_tok;
  logic hit_state;
  logic host_toggle;
  logic tok_write;

  function automatic logic legal_pid(input logic [3:0] p);
    return (p == pid_setup) || (p == pid_in) || (p == pid_out); // R18
  endfunction : legal_pid

  // writes land only at the access edge, where pready is sampled high
  assign wr_en     = psel & penable & pready & pwrite;
  assign rd_en     = psel & ~pwrite;
  assign hit_ctrl  = (paddr == off_usb_control);
  assign hit_addr  = (paddr == off_usb_device_address);
  assign hit_tok   = (paddr == off_token_command);
  assign hit_state = (paddr == off_core_state);
  assign ctrl_next = pwdata[7:0];
  assign host_toggle = wr_en & hit_ctrl &
                       (ctrl_next[bit_host_enable] != ctrl_reg[bit_host_enable]);
  // busy tokens are refused: software must poll first
  assign tok_write = wr_en & hit_tok & ctrl_reg[bit_host_enable] &
                     (tok_state_reg == tok_idle) & legal_pid(pwdata[7:4]); // R05

  // zero-wait slave: every access completes in its first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(hit_ctrl | hit_addr | hit_tok | hit_state);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      j_reg   <= 1'b0;
      se0_reg <= 1'b0;
    end else begin
      j_reg   <= line_j_state; // R01
      se0_reg <= line_se0;     // R02
    end
  end

  // bits 7,6,5 of ctrl_reg are unused; flags live in their own flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= control_reset_value;
    end else if (wr_en && hit_ctrl) begin
      ctrl_reg <= {3'b000, ctrl_next[4:0]}; // R06 R07 R09 R12 R13 R14 R17
    end
  end

  // set wins over a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_dis_reg <= 1'b0;
    end else if (setup_token_seen && !ctrl_reg[bit_host_enable]) begin
      pkt_dis_reg <= 1'b1; // R03
    end else if (wr_en && hit_ctrl && !ctrl_reg[bit_host_enable]) begin
      pkt_dis_reg <= ctrl_next[bit_packet_disable]; // R19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= address_reset_value;
    end else if (wr_en && hit_addr) begin
      addr_reg <= pwdata[7:0]; // R15 R16 R17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tok_reg       <= token_reset_value;
      tok_state_reg <= tok_idle;
      token_start   <= 1'b0;
    end else begin
      token_start <= 1'b0;
      if (host_toggle) begin
        tok_state_reg <= tok_idle; // R08
      end else begin
        case (tok_state_reg)
          tok_idle: begin
            if (tok_write) begin
              tok_reg       <= pwdata[7:0];
              token_start   <= 1'b1;
              tok_state_reg <= tok_busy; // R04
            end
          end
          tok_busy: begin
            if (token_done) begin
              tok_state_reg <= tok_idle; // R04
            end
          end
          default: tok_state_reg <= tok_idle;
        endcase
      end
    end
  end

  // sof timer runs only in host mode with bit 0 set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sof_cnt_reg <= 16'h0000;
      sof_pulse   <= 1'b0;
    end else begin
      sof_pulse <= 1'b0;
      if (!ctrl_reg[bit_host_enable] || !ctrl_reg[bit_module_enable] ||
          host_toggle) begin
        sof_cnt_reg <= 16'h0000; // R08
      end else if (sof_cnt_reg == 16'(sof_cycles - 1)) begin
        sof_cnt_reg <= 16'h0000;
        sof_pulse   <= 1'b1; // R14
      end else begin
        sof_cnt_reg <= sof_cnt_reg + 16'h0001;
      end
    end
  end

  // low-speed eop after resume falls in host mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eop_cnt_reg <= 8'h00;
    end else if (host_toggle) begin
      eop_cnt_reg <= 8'h00; // R08
    end else if (wr_en && hit_ctrl && ctrl_reg[bit_host_enable] &&
                 ctrl_reg[bit_resume] && !ctrl_next[bit_resume]) begin
      eop_cnt_reg <= 8'(ls_eop_cycles); // R11
    end else if (eop_cnt_reg != 8'h00) begin
      eop_cnt_reg <= eop_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processing_enabled <= 1'b0;
      bus_reset_out      <= 1'b0;
      resume_out         <= 1'b0;
      ls_eop_out         <= 1'b0;
      host_mode          <= 1'b0;
      host_logic_reset   <= 1'b0;
      pingpong_even      <= 1'b0;
      module_enabled     <= 1'b0;
      token_pid          <= 4'h0;
      token_ep           <= 4'h0;
      token_low_speed    <= 1'b0;
      device_address     <= 7'h00;
    end else begin
      processing_enabled <= ctrl_reg[bit_host_enable]
                          ? ctrl_reg[bit_module_enable]
                          : (ctrl_reg[bit_module_enable] &
                             ~pkt_dis_reg); // R03 R13
      bus_reset_out      <= ctrl_reg[bit_host_enable] &
                            ctrl_reg[bit_bus_reset_drive]; // R06
      resume_out         <= ctrl_reg[bit_resume]; // R09
      ls_eop_out         <= (eop_cnt_reg != 8'h00); // R11
      host_mode          <= ctrl_reg[bit_host_enable]; // R07
      host_logic_reset   <= host_toggle; // R08
      pingpong_even      <= ctrl_reg[bit_pingpong_reset]; // R12
      module_enabled     <= ~ctrl_reg[bit_host_enable] &
                            ctrl_reg[bit_module_enable]; // R13
      token_pid          <= tok_reg[7:4];
      token_ep           <= tok_reg[3:0];
      token_low_speed    <= addr_reg[bit_low_speed_select]; // R15
      device_address     <= addr_reg[addr_field_width-1:0]; // R16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      if (hit_ctrl) begin
        prdata <= {24'h000000, j_reg, se0_reg,
                   ctrl_reg[bit_host_enable] ? (tok_state_reg == tok_busy)
                                             : pkt_dis_reg,
                   ctrl_reg[4:0]}; // R01 R02 R04 R17
      end else if (hit_addr) begin
        prdata <= {24'h000000, addr_reg}; // R17
      end else if (hit_tok) begin
        prdata <= {24'h000000, tok_reg};
      end else if (hit_state) begin
        prdata <= {30'h0, ls_eop_out, sof_pulse};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule : usb_control_and_address_regs
`default_nettype wire

// ===== dv/usb_control_and_address_regs_monitor.sv
// port assertions for the usb control and address register block
// bound to every instance; single pclk domain, presetn disables
`timescale 1ns/1ps
`default_nettype none
module usb_regs_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        line_j_state,
  input wire logic        line_se0,
  input wire logic        setup_token_seen,
  input wire logic        processing_enabled,
  input wire logic        host_mode,
  input wire logic        host_logic_reset,
  input wire logic        module_enabled,
  input wire logic        sof_pulse,
  input wire logic        token_low_speed,
  input wire logic [6:0]  device_address
);
  wire logic rd_ctl = pready && !pwrite && paddr == 12'h000;
  wire logic rd_adr = pready && !pwrite && paddr == 12'h004;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  live_j_a: assert property (rd_ctl && $stable(line_j_state)
    |-> prdata[7] == line_j_state) else $error("j flag wrong");
  live_se0_a: assert property (rd_ctl && $stable(line_se0)
    |-> prdata[6] == line_se0) else $error("se0 flag wrong");
  upper_zero_a: assert property (pready && !pwrite
    |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
  addr_field_a: assert property (rd_adr && $stable(device_address)
    |-> prdata[6:0] == device_address) else $error("address out");
  low_speed_a: assert property (rd_adr && $stable(token_low_speed)
    |-> prdata[7] == token_low_speed) else $error("speed out");
  setup_halt_a: assert property (setup_token_seen && module_enabled
    |-> ##[1:3] !processing_enabled) else $error("no halt");
  host_reset_a: assert property ($changed(host_mode) |->
    (host_logic_reset || $past(host_logic_reset)) or
    (##[1:2] host_logic_reset)) else $error("no host reset");
  sof_gap_a: assert property (sof_pulse
    |-> !module_enabled ##1 !sof_pulse [*8]) else $error("sof gap");
endmodule : usb_regs_monitor
bind usb_control_and_address_regs usb_regs_monitor mon (
  .pclk               (pclk),
  .presetn            (presetn),
  .pwrite             (pwrite),
  .paddr              (paddr),
  .prdata             (prdata),
  .pready             (pready),
  .line_j_state       (line_j_state),
  .line_se0           (line_se0),
  .setup_token_seen   (setup_token_seen),
  .processing_enabled (processing_enabled),
  .host_mode          (host_mode),
  .host_logic_reset   (host_logic_reset),
  .module_enabled     (module_enabled),
  .sof_pulse          (sof_pulse),
  .token_low_speed    (token_low_speed),
  .device_address     (device_address)
);
`default_nettype wire

// ===== dv/usb_far_end.sv
// far side of the usb cable: line states, setup arrival, token end
// bench commands the lines; token_done trails token_start
`timescale 1ns/1ps
`default_nettype none
module usb_far_end #(
  parameter int done_delay = 30
) (
  input  wire logic       pclk,
  input  wire logic       token_start,
  input  wire logic [1:0] line_cmd,
  input  wire logic       setup_cmd,
  output logic            line_j_state,
  output logic            line_se0,
  output logic            setup_token_seen,
  output logic            token_done
);
  int cnt = 0;
  assign line_j_state = line_cmd == 2'h1;
  assign line_se0 = line_cmd == 2'h2;
  // slow answer on purpose so the busy window can be read
  always @(posedge pclk) begin
    setup_token_seen <= setup_cmd;
    token_done <= cnt == 1;
    if (token_start) cnt <= done_delay;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : usb_far_end
`default_nettype wire

// ===== dv/usb_control_and_address_regs_test.sv
// self-checking bench for the usb control and address registers
// apb master here; far side from usb_far_end
`timescale 1ns/1ps
`default_nettype none
module usb_control_and_address_regs_test;
  import usb_ctl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, setup_cmd = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [1:0] line_cmd = 2'h0;
  logic pready, pslverr, line_j_state, line_se0, setup_token_seen;
  logic token_done, processing_enabled, bus_reset_out, resume_out;
  logic ls_eop_out, host_mode, host_logic_reset, pingpong_even;
  logic module_enabled, sof_pulse, token_start, token_low_speed;
  logic [3:0] token_pid, token_ep;
  logic [6:0] device_address;
  int errors = 0, check_count = 0, cyc = 0, h;
  usb_control_and_address_regs #(.sof_cycles(20)) dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .line_j_state       (line_j_state),
    .line_se0           (line_se0),
    .setup_token_seen   (setup_token_seen),
    .token_done         (token_done),
    .processing_enabled (processing_enabled),
    .bus_reset_out      (bus_reset_out),
    .resume_out         (resume_out),
    .ls_eop_out         (ls_eop_out),
    .host_mode          (host_mode),
    .host_logic_reset   (host_logic_reset),
    .pingpong_even      (pingpong_even),
    .module_enabled     (module_enabled),
    .sof_pulse          (sof_pulse),
    .token_start        (token_start),
    .token_pid          (token_pid),
    .token_ep           (token_ep),
    .token_low_speed    (token_low_speed),
    .device_address     (device_address)
  );
  usb_far_end far (
    .pclk             (pclk),
    .token_start      (token_start),
    .line_cmd         (line_cmd),
    .setup_cmd        (setup_cmd),
    .line_j_state     (line_j_state),
    .line_se0         (line_se0),
    .setup_token_seen (setup_token_seen),
    .token_done       (token_done)
  );
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask : rd
  // counts cycles with s high over a window of n edges
  task automatic see(ref logic s, input int n);
    h = 0;
    repeat (n) begin
      @(posedge pclk);
      if (s === 1'b1) h++;
    end
  endtask : see
  task automatic t_regs;
    rd(off_usb_control, 32'h0);
    rd(off_usb_device_address, 32'h0);
    apb(1'b1, off_usb_device_address, 32'hFFFFFFFF);
    rd(off_usb_device_address, 32'h000000FF);
    chk({token_low_speed, device_address}, 32'hFF);
    apb(1'b1, 12'h010, 32'h1);
    chk(err, 32'h1);
    rd(12'h010, 32'h0);
    apb(1'b1, off_usb_device_address, 32'h05);
    rd(off_usb_device_address, 32'h05);
    chk({token_low_speed, device_address}, 32'h05);
    line_cmd <= 2'h1;
    rd(off_usb_control, 32'h80);
    line_cmd <= 2'h2;
    rd(off_usb_control, 32'h40);
    line_cmd <= 2'h0;
    $display("regs test done");
  endtask : t_regs
  task automatic t_device;
    apb(1'b1, off_usb_control, 32'h01);
    see(module_enabled, 3);
    chk(processing_enabled, 32'h1);
    setup_cmd <= 1'b1;
    @(posedge pclk);
    setup_cmd <= 1'b0;
    see(module_enabled, 3);
    chk(processing_enabled, 32'h0);
    rd(off_usb_control, 32'h21);
    apb(1'b1, off_usb_control, 32'h03);
    see(module_enabled, 3);
    chk({processing_enabled, pingpong_even}, 32'h3);
    apb(1'b1, off_usb_control, 32'h05);
    see(module_enabled, 3);
    chk({resume_out, pingpong_even}, 32'h2);
    $display("device test done");
  endtask : t_device
  task automatic t_host;
    apb(1'b1, off_usb_control, 32'h09);
    see(module_enabled, 3);
    chk({host_mode, module_enabled}, 32'h2);
    see(sof_pulse, 40);
    chk(h, 32'h2);
    apb(1'b1, off_usb_control, 32'h1C);
    see(module_enabled, 3);
    chk({bus_reset_out, resume_out}, 32'h3);
    apb(1'b1, off_usb_control, 32'h08);
    see(ls_eop_out, 40);
    chk(h, ls_eop_cycles);
    apb(1'b1, off_token_command, {24'h0, pid_in, 4'h3});
    see(token_start, 6);
    chk({h[3:0], token_pid, token_ep}, {4'h1, pid_in, 4'h3});
    rd(off_usb_control, 32'h28);
    repeat (35) @(posedge pclk);
    rd(off_usb_control, 32'h08);
    apb(1'b1, off_token_command, {24'h0, 4'h2, 4'h3});
    see(token_start, 6);
    chk(h, 32'h0);
    apb(1'b1, off_usb_control, 32'h00);
    see(module_enabled, 3);
    chk(host_mode, 32'h0);
    $display("host test done");
  endtask : t_host
  // reset in mid-run must bring the address back to zero
  task automatic t_reset;
    apb(1'b1, off_usb_device_address, 32'h85);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({token_low_speed, device_address}, 32'h0);
    rd(off_usb_device_address, 32'h0);
    $display("reset test done");
  endtask : t_reset
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_device();
    t_host();
    t_reset();
    results();
  end
endmodule : usb_control_and_address_regs_test
`default_nettype wire
